// *** common/enc_readout_pkg.sv ***
// Constants shared by the encoder position and speed readout block.
// Assumes a 50 MHz system clock and a byte-addressed AHB-Lite register window.
package enc_readout_pkg;

    // Clock and measurement window timing.
    localparam int CLK_PERIOD_NS  = 20;
    localparam int WIN_TIME_NS    = 1_000_000;
    localparam int WIN_CYCLES     = WIN_TIME_NS / CLK_PERIOD_NS;

    // Register byte offsets.
    localparam logic [7:0] ADDR_REV_COUNT = 8'h00;
    localparam logic [7:0] ADDR_FRACTION  = 8'h04;
    localparam logic [7:0] ADDR_SPEED     = 8'h08;
    localparam logic [7:0] ADDR_PPR       = 8'h0C;
    localparam logic [7:0] ADDR_CONTROL   = 8'h10;

    // Field positions and reset values.
    localparam int          CTRL_ZERO_BIT  = 0;
    localparam logic [15:0] REV_RESET      = 16'h0000;
    localparam logic [15:0] FRAC_RESET     = 16'h0000;
    localparam logic [31:0] SPEED_RESET    = 32'h0000_0000;
    localparam logic [15:0] PPR_RESET      = 16'h0400;
    localparam logic [15:0] PPR_MIN        = 16'h0001;

    // Speed scaling: milliseconds per minute, and the reported limit in rpm.
    localparam logic [15:0] MS_PER_MIN     = 16'hEA60;
    localparam logic [31:0] SPEED_LIMIT    = 32'h0000_EA60;

    // Divider engine.
    localparam int          DIV_STEPS      = 32;

    typedef enum logic [0:0] {DIV_IDLE, DIV_RUN} div_state_t;

endpackage

// *** hdl/enc_readout.sv ***
// Encoder position and speed readout: quadrature decode, revolution and fraction
// tracking, 1 ms speed windows and an AHB-Lite register slave.
// Assumes encoder channels and the zero-search strobe are synchronous to sys_clk.
//
// Overview of operation
// - Full revolution count is an unsigned 16-bit value, readable as status.
// - Reset clears both the revolution count and the revolution fraction.
// - A finished zero search clears both the revolution count and the fraction.
// - Count goes up per forward revolution, down per reverse revolution.
// - Fraction is the partial revolution scaled over 0 to 65535.
// - Fraction rises with forward pulses and falls with reverse pulses.
// - Speed in rpm from pulses per 1 ms window, limited to 60000.
// - The reported speed refreshes once every 1 ms.
// - Speed is signed: positive forward, negative reverse.
// - Speed is the raw window result with no filtering.
`timescale 1ns/1ps

module enc_readout #(
    parameter int WinCycles = enc_readout_pkg::WIN_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        encA,
    input  wire logic        encB,
    input  wire logic        zeroSearchDone,
    output logic      [15:0] revCount,
    output logic      [15:0] revFraction,
    output logic      [31:0] speedRpm
);

    // Bus state.
    logic        wrPendQ, wrPendD;
    logic [7:0]  wrAddrQ, wrAddrD;
    logic [31:0] rdataQ, rdataD;
    logic [15:0] pprQ, pprD;
    logic        zeroCmdQ, zeroCmdD;

    // Position state.
    logic        encAPrevQ, encAPrevD;
    logic [15:0] pulseQ, pulseD;
    logic [15:0] revQ, revD;

    // Window state.
    logic [31:0]        winCntQ, winCntD;
    logic signed [16:0] winPulsesQ, winPulsesD;
    logic signed [16:0] snapQ, snapD;
    logic               speedPendQ, speedPendD;

    // Divider state.
    enc_readout_pkg::div_state_t divStateQ, divStateD;
    logic        jobSpeedQ, jobSpeedD;
    logic        negQ, negD;
    logic [31:0] numQ, numD;
    logic [32:0] remQ, remD;
    logic [31:0] quoQ, quoD;
    logic [5:0]  stepQ, stepD;
    logic [15:0] fracQ, fracD;
    logic [31:0] speedQ, speedD;

    // Decode and event terms.
    logic        stepFwd;
    logic        stepRev;
    logic        zeroClear;
    logic        winTick;
    logic        addrPhase;
    logic [16:0] snapMag;
    logic [32:0] remShift;

    // One x1 edge per pulse: the A rising edge counts, B gives the direction.
    always_comb
    begin
        stepFwd   = encA && !encAPrevQ && !encB;
        stepRev   = encA && !encAPrevQ && encB;
        zeroClear = zeroSearchDone || zeroCmdQ;
        winTick   = (winCntQ == 32'(WinCycles - 1));
        addrPhase = hsel && htrans[1] && hready;
        snapMag   = snapQ[16] ? 17'(-snapQ) : 17'(snapQ);
        remShift  = {remQ[31:0], numQ[31]};
    end

    // Bus slave: reads are sampled in the address phase so data is ready at once.
    always_comb
    begin
        wrPendD  = addrPhase && hwrite;
        wrAddrD  = addrPhase ? haddr[7:0] : wrAddrQ;
        rdataD   = rdataQ;
        pprD     = pprQ;
        zeroCmdD = 1'b0;
        if (addrPhase && !hwrite)
        begin
            case (haddr[7:0])
                enc_readout_pkg::ADDR_REV_COUNT: rdataD = {16'h0000, revQ};
                enc_readout_pkg::ADDR_FRACTION:  rdataD = {16'h0000, fracQ};
                enc_readout_pkg::ADDR_SPEED:     rdataD = speedQ;
                enc_readout_pkg::ADDR_PPR:       rdataD = {16'h0000, pprQ};
                default:                         rdataD = 32'h0000_0000;
            endcase
        end
        if (wrPendQ)
        begin
            case (wrAddrQ)
                enc_readout_pkg::ADDR_PPR:
                begin
                    // A zero setting would make the divider divide by zero, so it is raised to one.
                    if (hwdata[15:0] < enc_readout_pkg::PPR_MIN)
                        pprD = enc_readout_pkg::PPR_MIN;
                    else
                        pprD = hwdata[15:0];
                end
                enc_readout_pkg::ADDR_CONTROL:
                    zeroCmdD = hwdata[enc_readout_pkg::CTRL_ZERO_BIT];
                default: ;
            endcase
        end
    end

    // Bus registers; the slave never inserts wait states and always answers OKAY.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            wrPendQ   <= 1'b0;
            wrAddrQ   <= 8'h00;
            rdataQ    <= 32'h0000_0000;
            pprQ      <= enc_readout_pkg::PPR_RESET;
            zeroCmdQ  <= 1'b0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            wrPendQ   <= wrPendD;
            wrAddrQ   <= wrAddrD;
            rdataQ    <= rdataD;
            pprQ      <= pprD;
            zeroCmdQ  <= zeroCmdD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Position inside the turn wraps at the pulse setting and carries into revolutions.
    always_comb
    begin
        encAPrevD = encA;
        pulseD    = pulseQ;
        revD      = revQ;
        if (zeroClear)
        begin
            pulseD = 16'h0000;
            revD   = 16'h0000;
        end
        else if (stepFwd)
        begin
            if (pulseQ >= pprQ - 16'h0001)
            begin
                pulseD = 16'h0000;
                revD   = revQ + 16'h0001;
            end
            else
                pulseD = pulseQ + 16'h0001;
        end
        else if (stepRev)
        begin
            // A reverse step at pulse zero borrows from the count.
            if (pulseQ == 16'h0000)
            begin
                pulseD = pprQ - 16'h0001;
                revD   = revQ - 16'h0001;
            end
            else
                pulseD = pulseQ - 16'h0001;
        end
    end

    // Position registers.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            encAPrevQ <= 1'b0;
            pulseQ    <= 16'h0000;
            revQ      <= enc_readout_pkg::REV_RESET;
        end
        else
        begin
            encAPrevQ <= encAPrevD;
            pulseQ    <= pulseD;
            revQ      <= revD;
        end
    end

    // Signed pulse count per window; the pulse in the tick cycle joins the snapshot.
    always_comb
    begin
        winCntD    = winTick ? 32'h0000_0000 : winCntQ + 32'h0000_0001;
        winPulsesD = winPulsesQ;
        if (stepFwd)
            winPulsesD = winPulsesQ + 17'sd1;
        else if (stepRev)
            winPulsesD = winPulsesQ - 17'sd1;
        snapD      = winTick ? winPulsesD : snapQ;
        if (winTick)
            winPulsesD = 17'sd0;
        // A new tick wins over the start of the job that consumes the previous one.
        speedPendD = winTick || (speedPendQ && !(divStateQ == enc_readout_pkg::DIV_IDLE));
    end

    // Window registers.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            winCntQ    <= 32'h0000_0000;
            winPulsesQ <= 17'sd0;
            snapQ      <= 17'sd0;
            speedPendQ <= 1'b0;
        end
        else
        begin
            winCntQ    <= winCntD;
            winPulsesQ <= winPulsesD;
            snapQ      <= snapD;
            speedPendQ <= speedPendD;
        end
    end

    // One restoring divider serves both jobs; speed has priority when a window closed.
    // Sharing it costs at most 66 cycles of latency, far below the 1 ms window.
    always_comb
    begin
        divStateD = divStateQ;
        jobSpeedD = jobSpeedQ;
        negD      = negQ;
        numD      = numQ;
        remD      = remQ;
        quoD      = quoQ;
        stepD     = stepQ;
        fracD     = fracQ;
        speedD    = speedQ;
        case (divStateQ)
            enc_readout_pkg::DIV_IDLE:
            begin
                remD      = 33'h0_0000_0000;
                quoD      = 32'h0000_0000;
                stepD     = 6'd0;
                divStateD = enc_readout_pkg::DIV_RUN;
                if (speedPendQ)
                begin
                    jobSpeedD = 1'b1;
                    negD      = snapQ[16];
                    // Both factors are widened first so the product cannot lose its top bits.
                    numD      = 32'(snapMag) * 32'(enc_readout_pkg::MS_PER_MIN);
                end
                else
                begin
                    jobSpeedD = 1'b0;
                    negD      = 1'b0;
                    numD      = {pulseQ, 16'h0000};
                end
            end
            enc_readout_pkg::DIV_RUN:
            begin
                numD  = {numQ[30:0], 1'b0};
                stepD = stepQ + 6'd1;
                if (remShift >= {17'h0_0000, pprQ})
                begin
                    remD = remShift - {17'h0_0000, pprQ};
                    quoD = {quoQ[30:0], 1'b1};
                end
                else
                begin
                    remD = remShift;
                    quoD = {quoQ[30:0], 1'b0};
                end
                if (!jobSpeedQ && zeroClear)
                begin
                    // A fraction job already running at a clear is dropped so its stale result does not land.
                    divStateD = enc_readout_pkg::DIV_IDLE;
                end
                else if (stepQ == 6'(enc_readout_pkg::DIV_STEPS - 1))
                begin
                    divStateD = enc_readout_pkg::DIV_IDLE;
                    if (jobSpeedQ)
                    begin
                        // Raw result straight to the register, no averaging.
                        if (quoD > enc_readout_pkg::SPEED_LIMIT)
                            speedD = negQ ? 32'(-enc_readout_pkg::SPEED_LIMIT)
                                          : enc_readout_pkg::SPEED_LIMIT;
                        else
                            speedD = negQ ? 32'(-quoD) : quoD;
                    end
                    else
                        fracD = quoD[15:0];
                end
            end
            default:
                divStateD = enc_readout_pkg::DIV_IDLE;
        endcase
        if (zeroClear)
            fracD = 16'h0000;
    end

    // Divider registers and result outputs.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            divStateQ <= enc_readout_pkg::DIV_IDLE;
            jobSpeedQ <= 1'b0;
            negQ      <= 1'b0;
            numQ      <= 32'h0000_0000;
            remQ      <= 33'h0_0000_0000;
            quoQ      <= 32'h0000_0000;
            stepQ     <= 6'd0;
            fracQ     <= enc_readout_pkg::FRAC_RESET;
            speedQ    <= enc_readout_pkg::SPEED_RESET;
        end
        else
        begin
            divStateQ <= divStateD;
            jobSpeedQ <= jobSpeedD;
            negQ      <= negD;
            numQ      <= numD;
            remQ      <= remD;
            quoQ      <= quoD;
            stepQ     <= stepD;
            fracQ     <= fracD;
            speedQ    <= speedD;
        end
    end

    // Status outputs are straight register copies of the readable values.
    assign hrdata      = rdataQ;
    assign revCount    = revQ;
    assign revFraction = fracQ;
    assign speedRpm    = speedQ;

endmodule // enc_readout

// *** test/enc_readout_properties.sv ***
// Checker for the encoder readout: bus answers, position steps, clears and speed timing.
// Assumes it is bound to the readout top module and sees only that module's ports.
`timescale 1ns/1ps

module enc_readout_properties #(
    parameter int WinCycles = 200
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        encA,
    input wire logic        zeroSearchDone,
    input wire logic [15:0] revCount,
    input wire logic [15:0] revFraction,
    input wire logic [31:0] speedRpm
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    // Cycle position inside the speed window, counted from reset release.
    int winPos_q;
    int winPos_d;
    always_comb winPos_d = (winPos_q == WinCycles - 1) ? 0 : winPos_q + 1;
    always_ff @(posedge sys_clk) winPos_q <= rst ? 0 : winPos_d;

    // A lone pulse keeps the fraction divider from being masked by later pulses.
    sequence lonePulse;
        (!encA) [*8] ##1 encA ##1 (!encA) [*8];
    endsequence

    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus slave stalled or answered with an error");
    a_read_rev: assert property (hsel && htrans[1] && hready && !hwrite
        && haddr[7:0] == 8'h00 |=> hrdata == {16'h0000, $past(revCount)})
        else $error("revolution count read returned a wrong word");
    a_reset_zero: assert property ($past(rst) |-> revCount == 16'h0000
        && revFraction == 16'h0000 && speedRpm == 32'h0000_0000)
        else $error("outputs not cleared by reset");
    a_zero_clear: assert property (zeroSearchDone |=> revCount == 16'h0000
        && revFraction == 16'h0000)
        else $error("zero search did not clear the position");
    a_rev_step: assert property (!$stable(revCount) |-> revCount == 16'h0000
        || revCount == $past(revCount) + 16'h0001 || revCount == $past(revCount) - 16'h0001)
        else $error("revolution count jumped by more than one");
    a_rev_cause: assert property (!$stable(revCount) |-> revCount == 16'h0000
        || ($past(encA) && !$past(encA, 2)))
        else $error("revolution count changed without an encoder pulse");
    // A stale fraction run, then a speed run, may come before the run that sees the pulse.
    a_frac_moves: assert property (lonePulse |-> ##[1:92] !$stable(revFraction))
        else $error("fraction did not follow an encoder pulse");
    a_speed_limit: assert property ($signed(speedRpm) <= 60000
        && $signed(speedRpm) >= -60000)
        else $error("speed outside the rpm limit");
    a_speed_period: assert property (!$stable(speedRpm) |-> winPos_q >= 30
        && winPos_q <= 72)
        else $error("speed changed outside its window update slot");
endmodule // enc_readout_properties

bind enc_readout enc_readout_properties #(.WinCycles(WinCycles)) chk (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .encA(encA), .zeroSearchDone(zeroSearchDone),
    .revCount(revCount), .revFraction(revFraction), .speedRpm(speedRpm));

// *** test/encoder_model.sv ***
// Behavioural shaft encoder that turns the shaft a given number of pulses.
// Assumes the readout counts channel A rises and takes channel B as the direction.
`timescale 1ns/1ps

module encoder_model (
    input  wire logic sys_clk,
    output logic      encA,
    output logic      encB
);
    initial
    begin
        encA = 1'b0;
        encB = 1'b0;
    end

    // One rise every two cycles, the fastest the decoder allows, with A low between.
    task turn(input int n, input logic rev);
        for (int i = 0; i < n; i++)
        begin
            @(posedge sys_clk);
            encB <= rev;
            encA <= 1'b1;
            @(posedge sys_clk);
            encA <= 1'b0;
        end
    endtask
endmodule // encoder_model

// *** test/enc_readout_bench.sv ***
// Bench for the encoder readout: register reads, turns both ways, clears and speed.
// Assumes the encoder model drives the channels and the bench is the only bus master.
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
    $display("BAD %s exp %h got %h", n, e, s); end end

module enc_readout_bench;
    logic        sys_clk, rst, hsel, hwrite, hreadyout, hresp, encA, encB, zeroSearchDone;
    logic [31:0] haddr, hwdata, hrdata, speedRpm, r;
    logic [1:0]  htrans;
    logic [15:0] revCount, revFraction;
    int          errors, n_checks;

    // A short window keeps the run brief; speed scaling is still per 1 ms.
    enc_readout #(.WinCycles(200)) dut (.sys_clk(sys_clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .encA(encA), .encB(encB), .zeroSearchDone(zeroSearchDone), .revCount(revCount),
        .revFraction(revFraction), .speedRpm(speedRpm));
    encoder_model enc (.sys_clk(sys_clk), .encA(encA), .encB(encB));

    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    // One single transfer; the master waits on hready in both phases.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h00_0000, a}; hwrite <= w;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0; htrans <= 2'b00; hwdata <= d;
        do @(posedge sys_clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    // The fraction may need a stale run and a speed run before it settles, about 100 cycles.
    task wait_pos(input logic [15:0] rv, input logic [31:0] fr);
        repeat (120) @(posedge sys_clk);
        `CHK("revCount", rv, revCount)
        `CHK("revFraction", fr[15:0], revFraction)
        bus(1'b0, 8'h04, 32'h0000_0000, r);
        `CHK("fraction", fr, r)
    endtask

    task t_reset;
        logic [7:0]  a [6];
        logic [31:0] e [6];
        a = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20};
        e = '{32'h0, 32'h0, 32'h0, 32'h0000_0400, 32'h0, 32'h0};
        bus(1'b1, 8'h00, 32'h0000_1234, r);
        foreach (a[i])
        begin
            bus(1'b0, a[i], 32'h0000_0000, r);
            `CHK("reset read", e[i], r)
        end
        $display("test reset done");
    endtask

    // Full-speed turns give 100 pulses per window: 100 * 60000 / 1024 rpm.
    task t_turns;
        fork
            enc.turn(3584, 1'b0);
            begin
                repeat (1000) @(posedge sys_clk);
                `CHK("speed fwd", 32'h0000_16E3, speedRpm)
                bus(1'b0, 8'h08, 32'h0000_0000, r);
                `CHK("speed reg fwd", 32'h0000_16E3, r)
            end
        join
        wait_pos(16'h0003, 32'h0000_8000);
        fork
            enc.turn(768, 1'b1);
            begin
                repeat (1000) @(posedge sys_clk);
                `CHK("speed rev", 32'hFFFF_E91D, speedRpm)
                bus(1'b0, 8'h08, 32'h0000_0000, r);
                `CHK("speed reg rev", 32'hFFFF_E91D, r)
            end
        join
        wait_pos(16'h0002, 32'h0000_C000);
        repeat (500) @(posedge sys_clk);
        `CHK("speed stop", 32'h0000_0000, speedRpm)
        $display("test turns done");
    endtask

    task t_limit;
        bus(1'b1, 8'h0C, 32'h0000_0000, r);
        bus(1'b0, 8'h0C, 32'h0000_0000, r);
        `CHK("ppr floor", 32'h0000_0001, r)
        bus(1'b1, 8'h0C, 32'h0000_0004, r);
        bus(1'b0, 8'h0C, 32'h0000_0000, r);
        `CHK("ppr", 32'h0000_0004, r)
        @(posedge sys_clk) zeroSearchDone <= 1'b1;
        @(posedge sys_clk) zeroSearchDone <= 1'b0;
        wait_pos(16'h0000, 32'h0000_0000);
        fork
            enc.turn(602, 1'b0);
            begin
                repeat (1000) @(posedge sys_clk);
                `CHK("speed clamp", 32'h0000_EA60, speedRpm)
            end
        join
        wait_pos(16'h0096, 32'h0000_8000);
        bus(1'b1, 8'h10, 32'h0000_0001, r);
        wait_pos(16'h0000, 32'h0000_0000);
        enc.turn(1, 1'b1);
        wait_pos(16'hFFFF, 32'h0000_C000);
        enc.turn(1, 1'b0);
        wait_pos(16'h0000, 32'h0000_0000);
        $display("test limit done");
    endtask

    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog: the tests need about 12000 cycles.
    initial
    begin
        repeat (40000) @(posedge sys_clk);
        errors++;
        give_verdict;
    end

    initial
    begin
        rst = 1'b1; hsel = 1'b0; htrans = 2'b00; haddr = 32'h0; hwrite = 1'b0;
        hwdata = 32'h0; zeroSearchDone = 1'b0; errors = 0; n_checks = 0;
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset;
        t_turns;
        t_limit;
        give_verdict;
    end
endmodule // enc_readout_bench
